// ===== core/cctg_gen.sv
// timing generator that drives the interline sensor's logic timing pins
// assumes sampled pixel words arrive on adc_* in the clk domain
`timescale 1ns/1ns
module cctg_gen #(
    parameter int INTEG_W   = 24,
    parameter int OVER_ROWS = 4,
    parameter int OVER_COLS = 8
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          start,
    input  wire logic                          dual_mode,
    input  wire logic                          dump_rows_en,
    input  wire logic [9:0]                    dump_rows,
    input  wire logic [INTEG_W-1:0]            integ_cycles,
    input  wire logic [cctg_pkg::PIXW-1:0]     adc_data,
    input  wire logic                          adc_valid,
    output logic                               busy_ff,
    output logic                               shutter_trigger_ff,
    output logic                               photodiode_transfer_phase_ff,
    output logic                               vertical_phase_two_shift_ff,
    output logic                               vertical_phase_one_ff,
    output logic                               fast_row_dump_ff,
    output logic                               horizontal_phase_one_ff,
    output logic                               horizontal_phase_two_ff,
    output logic                               dark_ref_ff,
    output logic                               pix_image_ff,
    output logic [cctg_pkg::PIXW-1:0]          pix_data,
    output logic                               pix_valid,
    input  wire logic                          pix_ready
);
    import cctg_pkg::*;
    cctg_state_t   st_ff, nxt_st;
    logic [INTEG_W-1:0] cnt_ff, nxt_cnt;
    logic [10:0]   hcnt_ff, nxt_hcnt;
    logic [10:0]   row_ff, nxt_row;
    logic [2:0]    hdiv_ff, nxt_hdiv;
    logic          sh, xf, v2, v1, fd, h1, h2, bsy, dref, img, dump_row;
    logic          fifo_ready;
    logic [PIXW-1:0] adc_s1_ff, adc_s2_ff;
    logic          adv_s1_ff, adv_s2_ff;
    logic [10:0]   line_len, rows_end;

    // ****************************************
    // input synchroniser for sampled pixels
    // ****************************************
    always_ff @(posedge clk) begin
        adc_s1_ff <= adc_data;
        adc_s2_ff <= adc_s1_ff;
        adv_s1_ff <= reset ? 1'b0 : adc_valid;
        adv_s2_ff <= reset ? 1'b0 : adv_s1_ff;
    end

    // overclock: extra columns and rows beyond the array give the zero level
    assign line_len = dual_mode ? 11'(LINE_DUAL + OVER_COLS)
                                : 11'(LINE_SINGLE + OVER_COLS);
    assign rows_end = 11'(ROWS_TOTAL + OVER_ROWS);

    // ****************************************
    // capture sequencer
    // ****************************************
    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_hcnt = hcnt_ff;
        nxt_row  = row_ff;
        nxt_hdiv = hdiv_ff;
        sh = 1'b0; xf = 1'b0; v2 = 1'b0; v1 = 1'b0; fd = 1'b0;
        h1 = 1'b1; h2 = 1'b0; bsy = 1'b1; dref = 1'b0; img = 1'b0;
        dump_row = 1'b0;
        case (st_ff)
            CCTG_IDLE: begin
                bsy = 1'b0;
                if (start) begin
                    nxt_st  = CCTG_SHUT;
                    nxt_cnt = '0;
                end
            end
            CCTG_SHUT: begin
                sh      = 1'b1;
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == INTEG_W'(SHUTTER_CYC - 1)) begin
                    nxt_st  = CCTG_INTEG;
                    nxt_cnt = '0;
                end
            end
            CCTG_INTEG: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= integ_cycles) begin
                    nxt_st  = CCTG_XFER;
                    nxt_cnt = '0;
                end
            end
            CCTG_XFER: begin
                xf = 1'b1;
                v1 = 1'b1;
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == INTEG_W'(XFER_CYC - 1)) begin
                    nxt_st  = CCTG_SETTLE;
                    nxt_cnt = '0;
                    nxt_row = '0;
                end
            end
            CCTG_SETTLE: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == INTEG_W'(VSETTLE_CYC - 1)) begin
                    nxt_st  = CCTG_VSHIFT;
                    nxt_cnt = '0;
                end
            end
            CCTG_VSHIFT: begin
                // horizontal clocks parked h1 high, h2 low by defaults
                // last cycle low: back-to-back dumped rows each need their own pulse
                dump_row = dump_rows_en && (row_ff < {1'b0, dump_rows});
                v2 = (cnt_ff != INTEG_W'(VSHIFT_CYC - 1));
                v1 = v2;
                fd = v2 && dump_row;
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == INTEG_W'(VSHIFT_CYC - 1)) begin
                    nxt_cnt  = '0;
                    nxt_hcnt = '0;
                    nxt_hdiv = '0;
                    nxt_row  = row_ff + 1'b1;
                    nxt_st   = dump_row ? CCTG_VSHIFT : CCTG_HREAD;
                    if (dump_row && (row_ff + 1'b1 == rows_end)) begin
                        nxt_st = CCTG_IDLE;
                    end
                end
            end
            CCTG_HREAD: begin
                // sh, vertical and dump stay low while pixels shift out
                // dual vs single set only by line length and image column count; h1/h2 phasing is the same
                h1 = (hdiv_ff < 3'(HDIV / 2 + 1));
                h2 = ~h1;
                // dark ref: centre ten of the left dark columns, not bottom rows
                dref = (hcnt_ff >= 11'(DARK_REF_FIRST)) && (hcnt_ff <= 11'(DARK_REF_LAST))
                       && (row_ff > 11'(DARK_ROWS_BOTTOM));
                // each half carries half the image columns in dual mode
                img  = (hcnt_ff >= 11'(EMPTY_PIX + DARK_PIX))
                       && (hcnt_ff < (dual_mode ? 11'(EMPTY_PIX + DARK_PIX + IMAGE_PIX / 2)
                                                : 11'(EMPTY_PIX + DARK_PIX + IMAGE_PIX)))
                       && (row_ff <= 11'(ROWS_TOTAL))
                       && (row_ff > 11'(DARK_ROWS_BOTTOM));
                nxt_hdiv = (hdiv_ff == 3'(HDIV - 1)) ? 3'd0 : hdiv_ff + 1'b1;
                if (hdiv_ff == 3'(HDIV - 1)) begin
                    nxt_hcnt = hcnt_ff + 1'b1;
                    if (hcnt_ff == line_len - 1'b1) begin
                        nxt_st = (row_ff == rows_end) ? CCTG_IDLE : CCTG_VSHIFT;
                    end
                end
            end
            default: nxt_st = CCTG_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff   <= CCTG_IDLE;
            cnt_ff  <= '0;
            hcnt_ff <= '0;
            row_ff  <= '0;
            hdiv_ff <= '0;
            busy_ff <= 1'b0;
            shutter_trigger_ff           <= 1'b0;
            photodiode_transfer_phase_ff <= 1'b0;
            vertical_phase_two_shift_ff  <= 1'b0;
            vertical_phase_one_ff        <= 1'b0;
            fast_row_dump_ff             <= 1'b0;
            horizontal_phase_one_ff      <= 1'b1;
            horizontal_phase_two_ff      <= 1'b0;
            dark_ref_ff                  <= 1'b0;
            pix_image_ff                 <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            hcnt_ff <= nxt_hcnt;
            row_ff  <= nxt_row;
            hdiv_ff <= nxt_hdiv;
            busy_ff <= bsy;
            shutter_trigger_ff           <= sh;
            photodiode_transfer_phase_ff <= xf;
            vertical_phase_two_shift_ff  <= v2;
            vertical_phase_one_ff        <= v1;
            fast_row_dump_ff             <= fd;
            horizontal_phase_one_ff      <= h1;
            horizontal_phase_two_ff      <= h2;
            dark_ref_ff                  <= dref;
            pix_image_ff                 <= img;
        end
    end

    // ****************************************
    // pixel buffer; a full fifo drops samples, the adc cannot be paused
    // ****************************************
    cctg_fifo #(.WIDTH(PIXW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (adc_s2_ff),
        .in_valid  (adv_s2_ff),
        .in_ready  (fifo_ready),
        .out_data  (pix_data),
        .out_valid (pix_valid),
        .out_ready (pix_ready)
    );

    // ****************************************
    // checks
    // ****************************************
    sequence s_shut_pulse;
        shutter_trigger_ff [*8];
    endsequence
    a_shutter_width: assert property (@(posedge clk) disable iff (reset)
        $rose(shutter_trigger_ff) |-> s_shut_pulse)
        else $error("shutter pulse too short");
    a_hclk_parked: assert property (@(posedge clk) disable iff (reset)
        vertical_phase_one_ff |-> horizontal_phase_one_ff && !horizontal_phase_two_ff)
        else $error("horizontal clocks not parked during vertical shift");
    a_quiet_readout: assert property (@(posedge clk) disable iff (reset)
        horizontal_phase_two_ff |-> !shutter_trigger_ff && !vertical_phase_one_ff
        && !fast_row_dump_ff && !photodiode_transfer_phase_ff)
        else $error("noisy inputs active in readout");
    a_xfer_order: assert property (@(posedge clk) disable iff (reset)
        $fell(shutter_trigger_ff) |-> !photodiode_transfer_phase_ff [*2])
        else $error("transfer overlaps shutter end");
    a_xfer_with_v1: assert property (@(posedge clk) disable iff (reset)
        photodiode_transfer_phase_ff |-> vertical_phase_one_ff && !vertical_phase_two_shift_ff)
        else $error("transfer pulse without phase one");
    a_dump_in_shift: assert property (@(posedge clk) disable iff (reset)
        fast_row_dump_ff |-> vertical_phase_two_shift_ff)
        else $error("dump outside vertical shift");
    a_dark_not_img: assert property (@(posedge clk) disable iff (reset)
        dark_ref_ff |-> !pix_image_ff)
        else $error("dark reference overlaps image");
    a_dark_rows: assert property (@(posedge clk) disable iff (reset)
        (row_ff <= 11'(DARK_ROWS_BOTTOM)) |=> !dark_ref_ff)
        else $error("dark rows used as reference");
endmodule // cctg_gen

// ===== core/cctg_pkg.sv
// package of constants for the sensor timing generator
// assumes a 50 MHz system clock; sensor pins are plain logic outputs
package cctg_pkg;
    // ****************************************
    // clock and pulse times
    // ****************************************
    localparam int CLK_MHZ           = 50;
    localparam int SHUTTER_US        = 4;
    localparam int XFER_US           = 10;
    localparam int SHUTTER_CYC       = SHUTTER_US * CLK_MHZ;
    localparam int XFER_CYC          = XFER_US * CLK_MHZ;
    localparam int VSETTLE_US        = 10;
    localparam int VSETTLE_CYC       = VSETTLE_US * CLK_MHZ;
    localparam int VSHIFT_US         = 2;
    localparam int VSHIFT_CYC        = VSHIFT_US * CLK_MHZ;
    localparam int HDIV              = 5;
    // ****************************************
    // line and frame layout
    // ****************************************
    localparam int EMPTY_PIX         = 8;
    localparam int DARK_PIX          = 12;
    localparam int IMAGE_PIX         = 1004;
    localparam int LINE_SINGLE       = EMPTY_PIX + DARK_PIX + IMAGE_PIX + DARK_PIX;
    localparam int LINE_DUAL         = 523;
    localparam int ROWS_TOTAL        = 1008;
    localparam int DARK_ROWS_BOTTOM  = 4;
    localparam int DARK_REF_FIRST    = EMPTY_PIX + 1;
    localparam int DARK_REF_LAST     = EMPTY_PIX + DARK_PIX - 2;
    localparam int FPS_SINGLE        = 30;
    localparam int FPS_DUAL          = 48;
    localparam int PIXW              = 14;
    localparam int FIFO_DEPTH        = 16;
    typedef enum logic [2:0] {
        CCTG_IDLE   = 3'b000,
        CCTG_SHUT   = 3'b001,
        CCTG_INTEG  = 3'b011,
        CCTG_XFER   = 3'b010,
        CCTG_SETTLE = 3'b110,
        CCTG_VSHIFT = 3'b111,
        CCTG_HREAD  = 3'b101
    } cctg_state_t;
endpackage

// ===== core/cctg_fifo.sv
// small synchronous fifo for digitised pixel samples
// assumes one clock domain; drain side may stall
`timescale 1ns/1ns
module cctg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;
    // ****************************************
    // pointer and count update
    // ****************************************
    always_comb begin
        push    = in_valid && (cnt_ff != (AW+1)'(DEPTH));
        pop     = out_ready && (cnt_ff != '0);
        nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
endmodule // cctg_fifo

// ===== testbench/cctg_sensor_model.sv
// sensor model: watches the timing pins, reports pulse widths and line counts
// assumes the pins are registered on the same clk as this model
`timescale 1ns/1ns
module cctg_sensor_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        shutter_trigger,
    input  wire logic        photodiode_transfer_phase,
    input  wire logic        vertical_phase_two_shift,
    input  wire logic        vertical_phase_one,
    input  wire logic        fast_row_dump,
    input  wire logic        horizontal_phase_one,
    input  wire logic        horizontal_phase_two,
    output logic             res_valid,
    output logic [2:0]       res_kind,
    output logic [31:0]      res_val,
    output logic [15:0]      viol_count
);
    // ****************************************
    // pin history, charge flags and counters
    // ****************************************
    logic        p_sh, p_tx, p_v2, p_h1, dump_l, seen_v, integrating;
    logic [15:0] sh_w, tx_w, h_cnt, t_now, t_shf;
    // charge is a flag only; analog levels are not modelled
    always_ff @(posedge clk) begin
        res_valid <= 1'b0;
        if (reset) begin
            {p_sh, p_tx, p_v2, p_h1, dump_l, seen_v, integrating} <= '0;
            {sh_w, tx_w, h_cnt, t_now, t_shf, viol_count} <= '0;
        end else begin
            p_sh  <= shutter_trigger;
            p_tx  <= photodiode_transfer_phase;
            p_v2  <= vertical_phase_two_shift;
            p_h1  <= horizontal_phase_one;
            t_now <= t_now + 16'h1;
            sh_w  <= shutter_trigger ? sh_w + 16'h1 : 16'h0;
            tx_w  <= photodiode_transfer_phase ? tx_w + 16'h1 : 16'h0;
            if (shutter_trigger) begin // all photodiodes emptied at once
                integrating <= 1'b0;
                seen_v      <= 1'b0;
            end
            if (p_sh && !shutter_trigger) begin // exposure opens here
                integrating <= 1'b1;
                t_shf       <= t_now;
                res_valid   <= 1'b1;
                res_kind    <= 3'h1;
                res_val     <= {16'h0, sh_w};
            end
            if (p_tx && !photodiode_transfer_phase) begin // end of the transfer pulse closes it
                integrating <= 1'b0;
                res_valid   <= 1'b1;
                res_kind    <= 3'h2;
                res_val     <= {t_now - t_shf, tx_w};
            end
            // phase one is parked high before a line, so its fall marks every pixel
            if (!horizontal_phase_one && p_h1)
                h_cnt <= h_cnt + 16'h1; // one pixel per horizontal cycle
            if (vertical_phase_two_shift && !p_v2) begin // both phases step rows
                seen_v    <= 1'b1;
                h_cnt     <= 16'h0;
                dump_l    <= fast_row_dump;
                res_valid <= seen_v;
                res_kind  <= 3'h4;
                res_val   <= {dump_l, 15'h0, h_cnt};
            end else if (vertical_phase_two_shift) begin
                dump_l <= dump_l | fast_row_dump; // dumped row skips the read
            end
            // overlaps that would smear charge or couple noise into sampling
            if ((photodiode_transfer_phase && !vertical_phase_one)
                || (vertical_phase_two_shift && (!horizontal_phase_one || horizontal_phase_two))
                || (horizontal_phase_two && (shutter_trigger || photodiode_transfer_phase
                    || vertical_phase_two_shift || vertical_phase_one || fast_row_dump)))
                viol_count <= viol_count + 16'h1;
        end
    end
endmodule // cctg_sensor_model

// ===== testbench/cctg_gen_tb.sv
// bench for the sensor timing generator: capture sequence and sample fifo
// assumes the sensor model reports one pin figure per cycle on res_*
`timescale 1ns/1ns
module cctg_gen_tb;
    import cctg_pkg::*;
    localparam int OC = 8;
    logic            clk, reset, start, dual_mode, dump_rows_en, adc_valid, pix_ready;
    logic [9:0]      dump_rows;
    logic [23:0]     integ_cycles;
    logic [PIXW-1:0] adc_data, pix_data;
    logic            busy_ff, sh, tx, v2, v1, fd, h1, h2, res_valid, pix_valid;
    logic            dark_ref, pix_image;
    logic [2:0]      res_kind;
    logic [31:0]     res_val;
    logic [15:0]     viol_count;
    logic [34:0]     exp_q[$];
    logic [PIXW-1:0] pix_q[$];
    int              mismatches, check_count, dark_n, image_n;
    integer          seed;
    // ****************************************
    // clock, design and sensor model
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    cctg_gen #(.OVER_COLS(OC)) u_dut (.clk(clk), .reset(reset), .start(start),
        .dual_mode(dual_mode), .dump_rows_en(dump_rows_en), .dump_rows(dump_rows),
        .integ_cycles(integ_cycles), .adc_data(adc_data), .adc_valid(adc_valid),
        .busy_ff(busy_ff), .shutter_trigger_ff(sh), .photodiode_transfer_phase_ff(tx),
        .vertical_phase_two_shift_ff(v2), .vertical_phase_one_ff(v1), .fast_row_dump_ff(fd),
        .horizontal_phase_one_ff(h1), .horizontal_phase_two_ff(h2), .dark_ref_ff(dark_ref),
        .pix_image_ff(pix_image), .pix_data(pix_data), .pix_valid(pix_valid),
        .pix_ready(pix_ready));
    cctg_sensor_model u_sensor (.clk(clk), .reset(reset), .shutter_trigger(sh),
        .photodiode_transfer_phase(tx), .vertical_phase_two_shift(v2),
        .vertical_phase_one(v1), .fast_row_dump(fd), .horizontal_phase_one(h1),
        .horizontal_phase_two(h2), .res_valid(res_valid), .res_kind(res_kind),
        .res_val(res_val), .viol_count(viol_count));
    task automatic tick();
        @(posedge clk);
        #2;
    endtask
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic close_out();
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic note(input logic [2:0] k, input logic [31:0] v);
        exp_q.push_back({k, v});
    endtask
    // every wait is bounded; running out ends the run as a failure
    task automatic wait_drain(input int bound);
        for (int i = 0; i < bound && (exp_q.size() + pix_q.size()) != 0; i++)
            tick();
        if ((exp_q.size() + pix_q.size()) != 0) begin
            check(1'b0, "wait ran out");
            close_out();
        end
    endtask
    // one capture cut short by reset once the first read line is counted
    task automatic capture(input logic dual);
        logic [23:0] n;
        n = 24'($random(seed)) & 24'h3f;
        dual_mode    = dual;
        dump_rows_en = 1'b1;
        // single reads a bottom dark row first, dual reads the first lit row
        dump_rows    = dual ? 10'h4 : 10'h3;
        integ_cycles = n;
        dark_n       = 0;
        image_n      = 0;
        note(3'h1, 32'(SHUTTER_CYC));
        note(3'h2, {16'(n + 24'd1 + 24'(XFER_CYC)), 16'(XFER_CYC)});
        repeat (dual ? 4 : 3) note(3'h4, 32'h8000_0000);
        note(3'h4, 32'(dual ? LINE_DUAL + OC : LINE_SINGLE + OC));
        start = 1'b1;
        tick();
        start = 1'b0;
        repeat (3) tick();
        check(busy_ff === 1'b1, "busy after start");
        start = 1'b1; // ignored while busy: a second shutter would show as extra
        tick();
        start = 1'b0;
        wait_drain(20000);
        check(viol_count === 16'h0, "pin overlap");
        check(dark_n == (dual ? (DARK_PIX - 2) * HDIV : 0), "dark columns");
        check(image_n == (dual ? IMAGE_PIX / 2 * HDIV : 0), "image pixels");
        reset = 1'b1;
        repeat (3) tick();
        reset = 1'b0;
    endtask
    // ****************************************
    // result watcher: oldest note against each result
    // ****************************************
    always @(posedge clk) begin
        if (dark_ref === 1'b1)
            dark_n++;
        if (pix_image === 1'b1)
            image_n++;
        if (res_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check(1'b0, "unexpected pin figure");
            else
                check({res_kind, res_val} === exp_q.pop_front(), "pin figure");
        end
        if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
            if (pix_q.size() == 0)
                check(1'b0, "extra sample word");
            else
                check(pix_data === pix_q.pop_front(), "sample word");
        end
    end
    initial begin
        seed = 32'hbb83b7b2;
        {reset, start, dual_mode, dump_rows_en, adc_valid, pix_ready} = 6'b100000;
        dump_rows    = 10'h0;
        integ_cycles = 24'h0;
        adc_data     = '0;
        mismatches   = 0;
        check_count  = 0;
        dark_n       = 0;
        image_n      = 0;
        repeat (3) @(posedge clk);
        #2;
        reset = 1'b0;
        check(h1 === 1'b1 && {sh, tx, v2, v1, fd, h2, busy_ff} === 7'h0, "reset levels");
        // overfill the fifo while the drain stalls; words past the depth drop
        for (int i = 0; i < 20; i++) begin
            adc_data  = PIXW'($random(seed));
            adc_valid = 1'b1;
            if (i < FIFO_DEPTH)
                pix_q.push_back(adc_data);
            tick();
            adc_valid = 1'b0;
            repeat (3) tick();
        end
        pix_ready = 1'b1;
        wait_drain(200);
        repeat (8) tick();
        capture(1'b0);
        capture(1'b1);
        close_out();
    end
endmodule // cctg_gen_tb
